// *** common/deerp_map.svh ***
`ifndef DEERP_MAP_SVH
`define DEERP_MAP_SVH
// ==========================================
// register map
`define DEERP_CSR_OFF 12'h02c
`define DEERP_ARR_BASE 12'h100
`define DEERP_CSR_RESET 8'h00
`define DEERP_BIT_START 0
`define DEERP_BIT_BWM 1
`define DEERP_BIT_IRQEN 2
// ==========================================
// timing
`define DEERP_ERASE_US 2000
`define DEERP_PROG_US 2000
`define DEERP_CLK_MHZ 25
`endif

// *** common/deerp_pkg.sv ***
package deerp_pkg;
	typedef enum logic [3:0] {
		DEERP_IDLE = 4'b0001,
		DEERP_ERASE = 4'b0010,
		DEERP_PROG = 4'b0100,
		DEERP_DONE = 4'b1000
	} deerp_state_e;
	// cpu side power and vector events
	typedef struct packed {
		logic wait_instruction;
		logic halt_instruction;
		logic vector_fetch;
	} deerp_cpu_s;
endpackage

// *** hdl/deerp_top.sv ***
`timescale 1ns/1ps
`include "deerp_map.svh"
// Functional notes
// - read mode serves array reads like ROM
// - write mode latches writes into sixteen latches
// - start bit programs latches into last written row
// - completion clears both bits, raises irq
// - vector fetch withdraws irq request
// - latches cleared at end/mode fall; AND
// - latched bytes cannot be read back
// - wait waits for running cycle end
// - halt aborts cycle immediately
// - array read in write mode returns zero
// - array write in read mode ignored
// - aborted cycle leaves cells unchanged
// - csr resets zero, bits 7:3 zero
// - software clears mode only when idle
// - start bit reads one while busy
// - erase and program timed internally
module deerp_top #(
	parameter int ERASE_CYC = (`DEERP_ERASE_US * `DEERP_CLK_MHZ),
	parameter int PROG_CYC = (`DEERP_PROG_US * `DEERP_CLK_MHZ),
	parameter int ROWS = 16
) (
	input wire logic hclk, // bus clock
	input wire logic hresetn, // async reset, low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write flag
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	input wire deerp_pkg::deerp_cpu_s cpu_evt, // cpu events
	output logic irq, // done interrupt request
	output logic wait_ack, // wait mode entered
	output logic halt_ack, // halt mode entered
	output logic busy // programming running
);
	import deerp_pkg::*;
	localparam int RB = $clog2(ROWS);
	localparam int CELLS = ROWS * 16;

	// ==========================================
	// parameter guard
	// the row index must be at least one bit wide, and the row number must fit the four row bits of the array window
	if (ERASE_CYC < 1 || PROG_CYC < 1 || ROWS < 2 || ROWS > 16) begin : g_bad_param
		$error("deerp_top: bad parameters");
	end

	// ==========================================
	// address decode, shared by the capture and read paths
	function automatic logic csr_hit(input logic [31:0] a);
		csr_hit = (a[11:0] == `DEERP_CSR_OFF);
	endfunction
	// only rows that exist answer; the rest of the window reads zero
	function automatic logic arr_hit(input logic [31:0] a);
		arr_hit = (a[11:8] == 4'(`DEERP_ARR_BASE >> 8)) && (int'(a[7:4]) < ROWS);
	endfunction
	// cell index of an array address: row above, column in the low nibble
	function automatic logic [RB+3:0] cell_idx(input logic [31:0] a);
		cell_idx = a[RB+3:0];
	endfunction

	// ==========================================
	// cell array and latch bank
	// the cells are plain storage; erase and program time is spent in the sequencer
	logic [7:0] cells [CELLS];
	logic [7:0] hold_r [16]; // latched bytes, write mode only
	logic [15:0] hold_v_r; // which latches hold a byte
	logic [RB-1:0] row_r; // row of the most recent array write
	logic prog_r; // start bit, reads one while busy
	logic bwm_r; // buffer write mode
	logic irqen_r; // done interrupt enable
	logic irq_r;
	logic wait_r;
	logic halt_r;
	deerp_state_e st_r;
	logic [31:0] cnt_r; // phase countdown

	// ==========================================
	// ahb address phase capture
	// only whole-word transfers are served; other sizes are not decoded
	logic ap_r, aw_r, acsr_r, aarr_r;
	logic [11:0] aa_r;
	wire take = hsel && hready && htrans[1] && (hsize == 3'h2);
	wire is_csr = csr_hit(haddr);
	wire is_arr = arr_hit(haddr);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_r <= 1'b0;
			aw_r <= 1'b0;
			acsr_r <= 1'b0;
			aarr_r <= 1'b0;
			aa_r <= 12'h000;
		end else begin
			ap_r <= take;
			aw_r <= hwrite;
			acsr_r <= take && is_csr;
			aarr_r <= take && is_arr;
			aa_r <= haddr[11:0];
		end
	end

	// ==========================================
	// data phase decode
	wire wr_csr = ap_r && aw_r && acsr_r;
	wire wr_arr = ap_r && aw_r && aarr_r && bwm_r && !prog_r;
	wire [3:0] col = aa_r[3:0];
	wire [7:0] wd = hwdata[7:0];
	wire done = (st_r == DEERP_DONE);
	// software may clear buffer mode only when start bit already clear
	wire bwm_clr_ok = !prog_r && !wd[`DEERP_BIT_BWM];
	// start needs write mode already set; a halt in the same cycle wins
	wire start = wr_csr && wd[`DEERP_BIT_START] && !prog_r && bwm_r && !halt_r;
	// clearing the start bit mid-cycle abandons the row; cells are left as they are
	wire sw_abort = wr_csr && prog_r && !wd[`DEERP_BIT_START];
	wire bwm_fall = bwm_r && ((wr_csr && bwm_clr_ok) || done);
	// the array answers from its address cycle, so no wait state is ever needed
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ==========================================
	// csr
	// completion and halt outrank a software write in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prog_r <= 1'b0;
			bwm_r <= 1'b0;
			irqen_r <= 1'b0;
		end else if (done || halt_r) begin
			prog_r <= 1'b0;
			bwm_r <= 1'b0;
		end else if (wr_csr) begin
			irqen_r <= wd[`DEERP_BIT_IRQEN];
			if (start)
				prog_r <= 1'b1;
			else if (sw_abort)
				prog_r <= 1'b0;
			if (wd[`DEERP_BIT_BWM] && !prog_r)
				bwm_r <= 1'b1;
			else if (bwm_clr_ok)
				bwm_r <= 1'b0;
		end
	end

	// ==========================================
	// latches: and-merge on rewrite, cleared at end or mode fall
	// a rewrite can only drop ones, as a cell cannot gain ones without an erase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_v_r <= 16'h0000;
			row_r <= '0;
		end else if (bwm_fall || halt_r) begin
			hold_v_r <= 16'h0000;
		end else if (wr_arr) begin
			hold_v_r[col] <= 1'b1;
			row_r <= aa_r[RB+3:4];
		end
	end
	// the data bytes carry no reset; the valid mask decides what is used
	always_ff @(posedge hclk) begin
		if (wr_arr)
			hold_r[col] <= hold_v_r[col] ? (hold_r[col] & wd) : wd;
	end

	// ==========================================
	// programming sequencer
	// erase chained into program; both spans are counted here, software supplies no timing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= DEERP_IDLE;
			cnt_r <= 32'h0;
		end else begin
			case (st_r)
				DEERP_IDLE: if (start) begin
					st_r <= DEERP_ERASE;
					cnt_r <= 32'(ERASE_CYC - 1);
				end
				DEERP_ERASE: if (halt_r || sw_abort) st_r <= DEERP_IDLE;
				else if (cnt_r == 0) begin
					st_r <= DEERP_PROG;
					cnt_r <= 32'(PROG_CYC - 1);
				end else cnt_r <= cnt_r - 32'h1;
				DEERP_PROG: if (halt_r || sw_abort) st_r <= DEERP_IDLE;
				else if (cnt_r == 0) st_r <= DEERP_DONE;
				else cnt_r <= cnt_r - 32'h1;
				DEERP_DONE: st_r <= DEERP_IDLE;
				default: st_r <= DEERP_IDLE;
			endcase
		end
	end
	// cells take latched bytes at the end of the program phase only
	always_ff @(posedge hclk) begin
		if (st_r == DEERP_PROG && cnt_r == 0 && !halt_r && !sw_abort) begin
			for (int i = 0; i < 16; i++)
				if (hold_v_r[i])
					cells[{row_r, 4'(i)}] <= hold_r[i];
		end
	end

	// ==========================================
	// interrupt, wait and halt
	// wait is only granted while idle, so a running cycle always finishes first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_r <= 1'b0;
			wait_r <= 1'b0;
			halt_r <= 1'b0;
		end else begin
			// completion beats a simultaneous vector fetch
			if (done && irqen_r)
				irq_r <= 1'b1;
			else if (cpu_evt.vector_fetch)
				irq_r <= 1'b0;
			wait_r <= cpu_evt.wait_instruction && !prog_r;
			halt_r <= cpu_evt.halt_instruction;
		end
	end
	assign irq = irq_r;
	assign wait_ack = wait_r;
	assign halt_ack = halt_r;
	assign busy = prog_r;

	// ==========================================
	// read data; no path from latches, array silent in write mode
	// an array read in write mode returns zero, standing in for the undriven bus
	wire [31:0] csr_rd = {29'h0, irqen_r, bwm_r, prog_r};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (take && !hwrite && is_csr)
			hrdata <= csr_rd;
		else if (take && !hwrite && is_arr && !bwm_r)
			hrdata <= {24'h0, cells[cell_idx(haddr)]};
		else
			hrdata <= 32'h0;
	end

	// ==========================================
	// checks
	// csr and completion
	chk_done_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		done |=> !prog_r && !bwm_r) else $error("done did not clear bits");
	chk_irq_set: assert property (@(posedge hclk) disable iff (!hresetn)
		done && irqen_r |=> irq) else $error("irq not raised");
	chk_irq_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		!irq && !(done && irqen_r) |=> !irq) else $error("irq raised without completion");
	chk_irq_drop: assert property (@(posedge hclk) disable iff (!hresetn)
		cpu_evt.vector_fetch && !done |=> !irq) else $error("irq not withdrawn");
	chk_busy_reads: assert property (@(posedge hclk) disable iff (!hresetn)
		start |=> prog_r [*3]) else $error("start bit not held");
	chk_mode_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		prog_r && !done && !halt_r |=> bwm_r) else $error("mode cleared while busy");
	chk_seq_chain: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r == DEERP_ERASE && cnt_r == 0 && !halt_r && !sw_abort |=> st_r == DEERP_PROG)
		else $error("erase not chained into program");

	// latch path
	chk_no_wr_read: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_arr |-> bwm_r) else $error("write latched in read mode");
	chk_latch_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		bwm_fall |=> hold_v_r == 16'h0000) else $error("latches kept");
	chk_hold_and: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_arr && hold_v_r[col] |=> hold_r[$past(col)] == $past(hold_r[col] & wd))
		else $error("rewrite did not merge");

	// read path and bus
	chk_silent_read: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && is_arr && bwm_r |=> hrdata == 32'h0) else $error("array drove in write mode");
	chk_csr_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && is_csr |=> hrdata[31:3] == 29'h0) else $error("reserved csr bits set");
	chk_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && !hresp) else $error("bus stalled or errored");

	// power modes
	chk_halt_abort: assert property (@(posedge hclk) disable iff (!hresetn)
		halt_r |=> st_r == DEERP_IDLE && !prog_r) else $error("halt did not abort");
	chk_halt_ack: assert property (@(posedge hclk) disable iff (!hresetn)
		cpu_evt.halt_instruction |=> halt_ack) else $error("halt not entered");
	chk_wait_busy: assert property (@(posedge hclk) disable iff (!hresetn)
		prog_r |=> !wait_ack) else $error("wait entered during cycle");
	chk_wait_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		cpu_evt.wait_instruction && !prog_r |=> wait_ack) else $error("wait not entered when idle");

	// main scenarios
	cov_program: cover property (@(posedge hclk) disable iff (!hresetn) done && hold_v_r != 16'h0000);
	cov_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq ##1 cpu_evt.vector_fetch);
	cov_and: cover property (@(posedge hclk) disable iff (!hresetn) wr_arr && hold_v_r[col]);
	cov_abort: cover property (@(posedge hclk) disable iff (!hresetn) sw_abort);
	cov_halt: cover property (@(posedge hclk) disable iff (!hresetn) halt_r && st_r != DEERP_IDLE);
endmodule

// *** bench/deerp_cpu_model.sv ***
`timescale 1ns/1ps
// ==========================================
// cpu core model: one word a transfer, data accesses only
module deerp_cpu_model (
	input wire logic hclk, // bus clock
	input wire logic hreadyout, // slave ready
	input wire logic [31:0] hrdata, // read data
	output logic hsel, // slave select
	output logic [31:0] haddr, // byte address
	output logic [1:0] htrans, // transfer type
	output logic hwrite, // write flag
	output logic [2:0] hsize, // transfer size
	output logic [31:0] hwdata, // write data
	output deerp_pkg::deerp_cpu_s cpu_evt // cpu events
);
	import deerp_pkg::*;
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		cpu_evt = '0;
	end
	// data fetches only, never code; bench keeps one row between cycles
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hwdata <= ~hwdata; // released data must not echo old value
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
endmodule

// *** bench/data_eeprom_row_programmer_tb.sv ***
`timescale 1ns/1ps
module data_eeprom_row_programmer_tb;
	import deerp_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, irq, wait_ack, halt_ack, busy;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	deerp_cpu_s cpu_evt;
	int mismatches = 0;
	int num_checks = 0;
	always #20 hclk = ~hclk;
	deerp_cpu_model i_cpu (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .cpu_evt(cpu_evt));
	deerp_top #(.ERASE_CYC(8), .PROG_CYC(8)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cpu_evt(cpu_evt), .irq(irq), .wait_ack(wait_ack),
		.halt_ack(halt_ack), .busy(busy));
	// ==========================================
	// shared helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset();
		i_cpu.xfer(1'b0, 32'h2c, 32'h0, q);
		check(q, 32'h0);
		check({busy, irq}, 2'b00);
		check({hresp, hreadyout}, 2'b01);
		i_cpu.xfer(1'b0, 32'h30, 32'h0, q);
		check(q, 32'h0);
	endtask
	// program two bytes of row 3, one of them written twice, with wait pending
	task automatic t_program();
		i_cpu.xfer(1'b1, 32'h130, 32'h55, q); // dropped in read mode
		i_cpu.xfer(1'b1, 32'h2c, 32'h02, q);
		i_cpu.xfer(1'b0, 32'h2c, 32'h0, q);
		check(q, 32'h02);
		i_cpu.xfer(1'b1, 32'h130, 32'hf0, q);
		i_cpu.xfer(1'b1, 32'h130, 32'h3c, q);
		i_cpu.xfer(1'b1, 32'h131, 32'ha5, q);
		i_cpu.xfer(1'b0, 32'h131, 32'h0, q);
		check(q, 32'h0);
		i_cpu.xfer(1'b1, 32'h2c, 32'h07, q);
		i_cpu.cpu_evt.wait_instruction <= 1'b1;
		i_cpu.xfer(1'b1, 32'h2c, 32'h05, q); // mode clear refused while busy
		i_cpu.xfer(1'b0, 32'h2c, 32'h0, q);
		check(q, 32'h07);
		#1 check(wait_ack, 1'b0);
		for (int i = 0; i < 40 && busy === 1'b1; i++) @(posedge hclk);
		repeat (2) @(posedge hclk);
		#1 check(wait_ack, 1'b1);
		i_cpu.cpu_evt.wait_instruction <= 1'b0;
		i_cpu.xfer(1'b0, 32'h2c, 32'h0, q);
		check(q, 32'h04);
		#1 check(irq, 1'b1);
		@(posedge hclk) i_cpu.cpu_evt.vector_fetch <= 1'b1;
		@(posedge hclk) i_cpu.cpu_evt.vector_fetch <= 1'b0;
		@(posedge hclk) #1 check(irq, 1'b0);
		i_cpu.xfer(1'b0, 32'h130, 32'h0, q);
		check(q[7:0], 8'h30);
		i_cpu.xfer(1'b0, 32'h131, 32'h0, q);
		check(q[7:0], 8'ha5);
	endtask
	// halt during a running cycle aborts it at once
	task automatic t_halt();
		i_cpu.xfer(1'b1, 32'h2c, 32'h02, q);
		i_cpu.xfer(1'b1, 32'h132, 32'h11, q);
		i_cpu.xfer(1'b1, 32'h2c, 32'h03, q);
		@(posedge hclk) i_cpu.cpu_evt.halt_instruction <= 1'b1;
		@(posedge hclk) i_cpu.cpu_evt.halt_instruction <= 1'b0;
		#1 check(halt_ack, 1'b1);
		i_cpu.xfer(1'b0, 32'h2c, 32'h0, q);
		check(q, 32'h0);
	endtask
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_program();
		t_halt();
		finish_test();
	end
	// watchdog: the run needs well under a thousand cycles
	initial begin
		#200000;
		mismatches++;
		finish_test();
	end
endmodule
